// [rtl/rrne_pkg.sv]
// package: opcodes, field layout, state and carrier types for the decoder and core
package rrne_pkg;
    localparam int OPCODE_W = 14;
    localparam int PC_W = 13;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    // fixed encodings
    localparam logic [13:0] OP_RETURN_FROM_IRQ = 14'h0009;
    localparam logic [13:0] NO_OP_MASK = 14'h3F9F;
    localparam logic [13:0] NO_OP_MATCH = 14'h0000;
    localparam logic [13:0] LIT_RETURN_MASK = 14'h3C00;
    localparam logic [13:0] LIT_RETURN_MATCH = 14'h3400;
    localparam logic [13:0] ROT_LEFT_MASK = 14'h3F00;
    localparam logic [13:0] ROT_LEFT_MATCH = 14'h0D00;
    // field positions
    localparam int DEST_BIT = 7;
    localparam int GLOBAL_IRQ_EN_BIT = 7;
    localparam int MSB_BIT = 7;
    // timing and reset values
    localparam int TWO_CYCLE_COUNT = 2;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] IRQCTL_RESET = 8'h00;

    typedef enum logic [1:0] {
        RRNE_FETCH = 2'b01,
        RRNE_FLUSH = 2'b10
    } rrne_state_type;

    // file register write request
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } rrne_fwrite_type;
endpackage : rrne_pkg

// [rtl/rrne_decode.sv]
// combinational opcode classifier for the four handled instructions
`timescale 1ns/1ps
module rrne_decode (
    input wire logic [13:0] i_opcode, // instruction word
    output logic o_no_op,             // no-operation match
    output logic o_rfi,               // return from irq match
    output logic o_lit_return,        // return with literal match
    output logic o_rot_left           // rotate left match
);
    // mask-and-match decode, return from irq an exact compare; don't-care bits are masked out
    always_comb begin
        o_no_op = (i_opcode & rrne_pkg::NO_OP_MASK)
                  == rrne_pkg::NO_OP_MATCH;
        o_rfi = i_opcode == rrne_pkg::OP_RETURN_FROM_IRQ;
        o_lit_return = (i_opcode & rrne_pkg::LIT_RETURN_MASK)
                       == rrne_pkg::LIT_RETURN_MATCH;
        o_rot_left = (i_opcode & rrne_pkg::ROT_LEFT_MASK)
                     == rrne_pkg::ROT_LEFT_MATCH;
    end
endmodule : rrne_decode

// [rtl/rrne_core.sv]
// execution of no-op, return-from-irq, return-with-literal and rotate-left
`timescale 1ns/1ps
module rrne_core (
    input wire logic I_CLK,               // core instruction clock
    input wire logic I_RESET,             // sync reset, active high
    input wire logic I_VALID,             // instruction word present
    input wire logic [13:0] I_OPCODE,     // instruction word
    input wire logic [12:0] I_STACK_TOP,  // return stack top value
    input wire logic [7:0] I_FILE_RDATA,  // addressed file register data
    output logic O_STACK_POP,             // pop pulse to return stack
    output logic O_FLUSH,                 // second cycle of two-cycle op
    output logic [12:0] O_PC,             // program counter
    output logic [7:0] O_ACC,             // working accumulator
    output logic O_CARRY,                 // carry flag
    output logic [7:0] O_IRQ_CONTROL,     // irq control register
    output logic O_FILE_WE,               // file register write
    output logic [6:0] O_FILE_ADDR,       // file register write address
    output logic [7:0] O_FILE_WDATA       // file register write data
);
    typedef struct packed {
        rrne_pkg::rrne_state_type st;
        logic [12:0] pc;
        logic [7:0] acc;
        logic carry;
        logic [7:0] irqctl;
        logic pop;
        rrne_pkg::rrne_fwrite_type fw;
    } rrne_regs_type;

    rrne_regs_type r;
    rrne_regs_type next_r;
    logic is_no_op;
    logic is_rfi;
    logic is_lit_return;
    logic is_rot_left;
    logic [7:0] rot;

    rrne_decode u_decode (
        .i_opcode(I_OPCODE),
        .o_no_op(is_no_op),
        .o_rfi(is_rfi),
        .o_lit_return(is_lit_return),
        .o_rot_left(is_rot_left)
    );

    // rotated value: old carry in at bit 0, old bit 7 leaves to carry
    assign rot = {I_FILE_RDATA[6:0], r.carry};

    // next state; other opcodes just advance the pc so the core keeps going
    always_comb begin
        next_r = r;
        next_r.pop = 1'b0;
        next_r.fw.en = 1'b0;
        unique case (r.st)
            rrne_pkg::RRNE_FETCH: begin
                if (I_VALID) begin
                    next_r.pc = r.pc + 13'h0001;
                    if (is_rfi) begin
                        next_r.pc = I_STACK_TOP;
                        next_r.pop = 1'b1;
                        // only the enable bit moves; the other control
                        // bits belong to the interrupt logic
                        next_r.irqctl[rrne_pkg::GLOBAL_IRQ_EN_BIT] =
                            1'b1;
                        next_r.st = rrne_pkg::RRNE_FLUSH;
                    end else if (is_lit_return) begin
                        next_r.acc = I_OPCODE[7:0];
                        next_r.pc = I_STACK_TOP;
                        next_r.pop = 1'b1;
                        next_r.st = rrne_pkg::RRNE_FLUSH;
                    end else if (is_rot_left) begin
                        next_r.carry =
                            I_FILE_RDATA[rrne_pkg::MSB_BIT];
                        if (I_OPCODE[rrne_pkg::DEST_BIT]) begin
                            next_r.fw.en = 1'b1;
                            next_r.fw.addr = I_OPCODE[6:0];
                            next_r.fw.data = rot;
                        end else begin
                            next_r.acc = rot;
                        end
                    end
                end
            end
            // flush cycle: fetched word discarded, nothing changes
            rrne_pkg::RRNE_FLUSH: begin
                next_r.st = rrne_pkg::RRNE_FETCH;
            end
        endcase
    end

    // state register; sync reset
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            r.st <= rrne_pkg::RRNE_FETCH;
            r.pc <= rrne_pkg::PC_RESET;
            r.acc <= rrne_pkg::ACC_RESET;
            r.carry <= 1'b0;
            r.irqctl <= rrne_pkg::IRQCTL_RESET;
            r.pop <= 1'b0;
            r.fw <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign O_STACK_POP = r.pop;
    assign O_FLUSH = r.st == rrne_pkg::RRNE_FLUSH;
    assign O_PC = r.pc;
    assign O_ACC = r.acc;
    assign O_CARRY = r.carry;
    assign O_IRQ_CONTROL = r.irqctl;
    assign O_FILE_WE = r.fw.en;
    assign O_FILE_ADDR = r.fw.addr;
    assign O_FILE_WDATA = r.fw.data;

    // assertions; all in the one core clock domain, so the clock and
    // the reset are given once here
    default clocking cb_core @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);

    // one sequence per kind of word taken in the fetch state
    sequence s_rfi_taken;
        r.st == rrne_pkg::RRNE_FETCH && I_VALID && is_rfi;
    endsequence
    sequence s_lit_return_taken;
        r.st == rrne_pkg::RRNE_FETCH && I_VALID && is_lit_return;
    endsequence
    sequence s_rot_left_taken;
        r.st == rrne_pkg::RRNE_FETCH && I_VALID && is_rot_left;
    endsequence
    sequence s_no_op_taken;
        r.st == rrne_pkg::RRNE_FETCH && I_VALID && is_no_op;
    endsequence
    // second step of a return: one discard cycle, then fetch again
    sequence s_discard_then_fetch;
        O_FLUSH ##1 !O_FLUSH;
    endsequence

    // return from irq: pc loaded from the stack top, stack popped
    AST_RFI_PC: assert property (
        s_rfi_taken |=> O_PC == $past(I_STACK_TOP) && O_STACK_POP)
        else $error("return from irq did not load pc from stack");

    // the pop request is a single pulse; a held pop would drop two frames
    AST_POP_PULSE: assert property (
        O_STACK_POP |=> !O_STACK_POP)
        else $error("stack pop held for more than one cycle");

    // return from irq re-enables interrupts
    AST_RFI_IRQ_EN: assert property (
        s_rfi_taken |=> O_IRQ_CONTROL[rrne_pkg::GLOBAL_IRQ_EN_BIT])
        else $error("global irq enable not set");

    // the other control bits are not touched by the return
    AST_RFI_OTHER_BITS: assert property (
        s_rfi_taken |=> O_IRQ_CONTROL[6:0] == $past(O_IRQ_CONTROL[6:0]))
        else $error("return from irq changed other control bits");

    // only reset in this block clears the enable once it is set
    AST_IRQ_EN_KEPT: assert property (
        O_IRQ_CONTROL[rrne_pkg::GLOBAL_IRQ_EN_BIT]
        |=> O_IRQ_CONTROL[rrne_pkg::GLOBAL_IRQ_EN_BIT])
        else $error("global irq enable dropped");

    // return from irq takes two cycles: the next word is discarded
    AST_RFI_TWO: assert property (
        s_rfi_taken |=> s_discard_then_fetch)
        else $error("return from irq not two cycles");

    // literal lands in the accumulator; carry and control untouched
    AST_LIT_RETURN_ACC: assert property (
        s_lit_return_taken |=> O_ACC == $past(I_OPCODE[7:0])
            && $stable(O_CARRY) && $stable(O_IRQ_CONTROL))
        else $error("literal return accumulator or flags wrong");

    // literal return also pops the stack into the pc
    AST_LIT_RETURN_PC: assert property (
        s_lit_return_taken |=> O_PC == $past(I_STACK_TOP) && O_STACK_POP)
        else $error("literal return pc or pop wrong");

    // and, like the other return, spends a discard cycle
    AST_LIT_RETURN_TWO: assert property (
        s_lit_return_taken |=> s_discard_then_fetch)
        else $error("literal return not two cycles");

    // rotate: carry takes bit 7, result to register or accumulator;
    // the write strobe must stay low when the accumulator is chosen
    AST_ROTATE_LEFT: assert property (
        s_rot_left_taken |=> O_CARRY == $past(I_FILE_RDATA[7]) &&
        ($past(I_OPCODE[7]) ? (O_FILE_WE &&
          O_FILE_ADDR == $past(I_OPCODE[6:0]) &&
          O_FILE_WDATA == {$past(I_FILE_RDATA[6:0]), $past(O_CARRY)})
        : (!O_FILE_WE &&
          O_ACC == {$past(I_FILE_RDATA[6:0]), $past(O_CARRY)})))
        else $error("rotate left result wrong");

    // rotate is a one-cycle instruction: no pop and no discard cycle
    AST_ROT_ONE_CYCLE: assert property (
        s_rot_left_taken |=> !O_FLUSH && !O_STACK_POP
            && O_PC == $past(O_PC) + 13'h0001)
        else $error("rotate left not a one-cycle instruction");

    // no-op: pc steps by one and nothing else moves
    AST_NO_OP: assert property (
        s_no_op_taken |=> O_PC == $past(O_PC) + 13'h0001
            && $stable(O_ACC) && $stable(O_CARRY)
            && $stable(O_IRQ_CONTROL) && !O_FLUSH
            && !O_FILE_WE && !O_STACK_POP)
        else $error("no-op changed state");

    // the word offered in a discard cycle is refused outright
    AST_FLUSH_IDLE: assert property (
        O_FLUSH |=> $stable(O_PC) && $stable(O_ACC) && $stable(O_CARRY)
            && !O_STACK_POP && !O_FILE_WE && !O_FLUSH)
        else $error("flush cycle changed state");
endmodule : rrne_core

// [bench/rrne_core_tb.sv]
// self-checking bench for the return, rotate and no-op executor
`timescale 1ns/1ps
module rrne_core_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    logic [13:0] op = 14'h0000;
    logic [12:0] top = 13'h0000;
    logic [7:0] rd = 8'h00;
    logic pop, flush, carry, we;
    logic [12:0] pc;
    logic [7:0] acc, irq, wdata;
    logic [6:0] waddr;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;

    rrne_core dut (.I_CLK(clk), .I_RESET(rst), .I_VALID(valid),
        .I_OPCODE(op), .I_STACK_TOP(top), .I_FILE_RDATA(rd),
        .O_STACK_POP(pop), .O_FLUSH(flush), .O_PC(pc), .O_ACC(acc),
        .O_CARRY(carry), .O_IRQ_CONTROL(irq), .O_FILE_WE(we),
        .O_FILE_ADDR(waddr), .O_FILE_WDATA(wdata));

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    // hang guard; the whole run needs well under a hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // case inequality so an unknown output never counts as a match
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // offer one word for a single taking edge, then look 1 ns later
    task automatic exec(input logic [13:0] o, input logic [12:0] t,
                        input logic [7:0] r);
        @(posedge clk);
        valid <= 1'b1;
        op <= o;
        top <= t;
        rd <= r;
        @(posedge clk);
        valid <= 1'b0;
        #1;
    endtask : exec

    // don't-care bits set: pc moves by one, nothing else changes
    task automatic t_idle;
        exec(14'h0060, 13'h1FFF, 8'hFF);
        chk(16'(pc), 16'h0001);
        chk({4'h0, acc, carry, pop, flush, we}, 16'h0000);
        chk(16'(irq), 16'h0000);
    endtask : t_idle

    // both destinations; carry in and out both exercised
    task automatic t_rot;
        exec(14'h0DA5, 13'h0000, 8'h96);
        chk({8'h00, we, waddr}, 16'h00A5);
        chk(16'(wdata), 16'h002C);
        chk({7'h00, carry, acc}, 16'h0100);
        exec(14'h0D25, 13'h0000, 8'hC1);
        chk({7'h00, carry, acc}, 16'h0183);
        chk(16'(we), 16'h0000);
    endtask : t_rot

    // carry is 1 beforehand and must survive the literal return
    task automatic t_lit(input logic [13:0] o, input logic [12:0] t);
        exec(o, t, 8'hFF);
        chk(16'(acc), 16'(o[7:0]));
        chk(16'(carry), 16'h0001);
        chk(16'(pc), 16'(t));
        chk({14'h0000, pop, flush}, 16'h0003);
    endtask : t_lit

    // return from irq, then valid held on through the discard cycle
    task automatic t_irq_ret;
        @(posedge clk);
        valid <= 1'b1;
        op <= 14'h0009;
        top <= 13'h1ABC;
        rd <= 8'h00;
        @(posedge clk);
        op <= 14'h0000;
        #1;
        chk(16'(pc), 16'h1ABC);
        chk(16'(pop), 16'h0001);
        chk(16'(irq), 16'h0080);
        chk(16'(flush), 16'h0001);
        @(posedge clk);
        valid <= 1'b0;
        #1;
        chk(16'(pc), 16'h1ABC);
        chk({14'h0000, pop, flush}, 16'h0000);
    endtask : t_irq_ret

    // reset in mid-run must clear the enable bit and the moved pc
    task automatic t_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({3'h0, pc}, 16'h0000);
        chk({irq, acc}, 16'h0000);
        chk({13'h0000, carry, pop, flush}, 16'h0000);
    endtask : t_reset

    // reset for two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({3'h0, pc}, 16'h0000);
        chk({irq, acc}, 16'h0000);
        t_idle();
        t_rot();
        t_lit(14'h34A5, 13'h0123);
        t_lit(14'h375A, 13'h1F00);
        t_irq_ret();
        t_reset();
        t_idle();
        close_out();
    end
endmodule : rrne_core_tb
